/* File: core/lics_defines.svh */
`ifndef LICS_DEFINES_SVH
`define LICS_DEFINES_SVH

// clock and derived timing
`define LICS_CLK_HZ          50000000
`define LICS_FILTER_US       1000
`define LICS_FILTER_CYC      (`LICS_CLK_HZ / 1000000 * `LICS_FILTER_US)
`define LICS_MS_CYC          (`LICS_CLK_HZ / 1000)
`define LICS_FLASH_PERIOD_MS 1600
`define LICS_FLASH_HALF_MS   (`LICS_FLASH_PERIOD_MS / 2)
`define LICS_PRECOND_MIN     32
`define LICS_PRECOND_MS      (`LICS_PRECOND_MIN * 60 * 1000)
`define LICS_SAFETY_A_HR     4
`define LICS_SAFETY_B_HR     6
`define LICS_SAFETY_C_HR     8
`define LICS_SAFETY_A_MS     (`LICS_SAFETY_A_HR * 3600 * 1000)
`define LICS_SAFETY_B_MS     (`LICS_SAFETY_B_HR * 3600 * 1000)
`define LICS_SAFETY_C_MS     (`LICS_SAFETY_C_HR * 3600 * 1000)

// register offsets (byte addresses)
`define LICS_CTRL_OFS        8'h00
`define LICS_STATUS_OFS      8'h04

// control fields
`define LICS_CTRL_W          10
`define LICS_AUTO_RCH_BIT    0
`define LICS_STYLE2_BIT      1
`define LICS_PRE_EN_BIT      2
`define LICS_PRE_TMR_BIT     3
`define LICS_SAFE_SEL_LSB    4
`define LICS_VREG_SEL_LSB    6
`define LICS_TERM_SEL_LSB    8
`define LICS_CTRL_RST        10'h00D
`define LICS_SAFE_OFF        2'h3

// status fields
`define LICS_ST_STATE_LSB    0
`define LICS_ST_HOLD_BIT     4
`define LICS_ST_FLASH_BIT    5
`define LICS_ST_OE_BIT       6
`define LICS_ST_LOCK_BIT     7

`endif

/* File: core/lics_pkg.sv */
package lics_pkg;

    // charge cycle states
    typedef enum logic [3:0] {
        ST_SHUTDOWN, ST_STANDBY, ST_SHORT_RECOVER, ST_PRECOND, ST_FAST_CC,
        ST_CONST_V, ST_COMPLETE, ST_TEMP_FAULT, ST_TIMER_FAULT, ST_PRE_TIMER_FAULT
    } lics_state_t;

    // comparator results from the analog front end
    typedef struct packed {
        logic batt_present;
        logic below_short;
        logic above_short_hyst;
        logic below_precond;
        logic at_regulation;
        logic above_reg_hyst;
        logic below_recharge;
        logic term_current_low;
        logic die_warm;
        logic die_hot;
        logic die_cooled;
        logic program_pin_attached;
    } lics_sense_t;

    // commands to the pass element and regulation loops
    typedef struct packed {
        logic pass_enable;
        logic detect_current;
        logic precond_current;
        logic fast_current;
        logic cv_regulate;
        logic current_derate;
    } lics_drive_t;

endpackage : lics_pkg

/* File: core/lics_sync.sv */
`timescale 1ns/1ps
module lics_sync #(
    parameter int unsigned W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // asynchronous in, synchronous out
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta;

    // two flops; the first is read only by the second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta     <= '0;
            sync_out <= '0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule : lics_sync

/* File: core/lics_timer.sv */
`timescale 1ns/1ps
module lics_timer #(
    parameter int unsigned W = 25
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // control
    input  wire logic         clear,
    input  wire logic         tick,
    input  wire logic [W-1:0] limit,
    // sticky expiry level
    output logic              expired
);
    logic [W-1:0] count;

    // counts ticks up to limit, then holds expired until cleared
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count   <= '0;
            expired <= 1'b0;
        end else if (clear) begin
            count   <= '0;
            expired <= 1'b0;
        end else if (tick && !expired) begin
            count <= count + 1'b1;
            if (count + 1'b1 >= limit) begin
                expired <= 1'b1;
            end
        end
    end
endmodule : lics_timer

/* File: core/lics_sequencer.sv */
// Functional notes
// - cc safety timeout gives timer fault
// - timer fault holds until battery removed
// - switch cc to cv at regulation voltage
// - cv ends when current below selected fraction
// - safety timer expiry also ends charge
// - termination comparator filtered for 1 ms
// - complete state restarts below recharge threshold
// - no-recharge option waits for reinsertion
// - derate current as die warms
// - suspend above 150C, resume after cooling
// - status pin open-drain, low or hi-z
// - status hi-z in shutdown, standby, complete
// - status low while precond, cc, cv
// - below short threshold, detect current only
// - leave short recovery above hysteresis
// - precondition until threshold, then fast charge
// - precondition timeout gives precondition fault
// - safety timer restarts entering cc
// - start below recharge, withhold above overvoltage
`timescale 1ns/1ps
`include "lics_defines.svh"
module lics_sequencer
    import lics_pkg::*;
#(
    parameter int unsigned FILTER_CYC    = `LICS_FILTER_CYC,
    parameter int unsigned MS_CYC        = `LICS_MS_CYC,
    parameter int unsigned FLASH_HALF_MS = `LICS_FLASH_HALF_MS,
    parameter int unsigned PRECOND_MS    = `LICS_PRECOND_MS,
    parameter int unsigned SAFETY_A_MS   = `LICS_SAFETY_A_MS,
    parameter int unsigned SAFETY_B_MS   = `LICS_SAFETY_B_MS,
    parameter int unsigned SAFETY_C_MS   = `LICS_SAFETY_C_MS,
    parameter int unsigned TMR_W         = 25
) (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // supply lockout comparators
    input  wire logic        input_low_lockout,
    input  wire logic        input_high_lockout,
    // analog comparator results
    input  wire lics_sense_t sense,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // analog drive and factory selections
    output lics_drive_t      drive,
    output logic      [1:0]  vreg_sel,
    output logic      [1:0]  term_sel,
    // open-drain status pin
    output logic             status_pin_out,
    output logic             status_pin_oe
);
    localparam int unsigned PW = $clog2(MS_CYC + 1);
    localparam int unsigned FW = $clog2(FILTER_CYC + 1);

    // refuse values the counters cannot hold
    if (MS_CYC < 2 || FILTER_CYC < 1 || FLASH_HALF_MS < 1 || PRECOND_MS < 1 || SAFETY_A_MS < 1
        || SAFETY_B_MS < 1 || SAFETY_C_MS < 1 || TMR_W > 31
        || PRECOND_MS >= (1 << TMR_W) || SAFETY_C_MS >= (1 << TMR_W)
        || SAFETY_A_MS >= (1 << TMR_W) || SAFETY_B_MS >= (1 << TMR_W)
        || FLASH_HALF_MS >= (1 << TMR_W)) begin : g_bad_params
        $error("lics_sequencer: timing parameters out of range");
    end

    lics_state_t            state;
    lics_state_t            next_state;
    lics_sense_t            sn;
    logic                   lock_s;
    logic [1:0]             lock_raw;
    logic [`LICS_CTRL_W-1:0] ctrl;
    logic [PW-1:0]          ms_cnt;
    logic                   ms_tick;
    logic                   filter_done;
    logic                   pre_exp;
    logic                   safety_exp;
    logic                   safety_done;
    logic                   pre_done;
    logic                   flash_exp;
    logic                   flash_phase;
    logic                   term_hold;
    logic                   in_fault;
    logic                   in_charge;
    logic                   style2;
    logic                   auto_rch;
    logic                   pre_en;
    logic [1:0]             safe_sel;
    logic [FW-1:0]          term_run;

    assign style2   = ctrl[`LICS_STYLE2_BIT];
    assign auto_rch = ctrl[`LICS_AUTO_RCH_BIT];
    assign pre_en   = ctrl[`LICS_PRE_EN_BIT];
    assign safe_sel = ctrl[`LICS_SAFE_SEL_LSB +: 2];
    assign vreg_sel = ctrl[`LICS_VREG_SEL_LSB +: 2];  // 4.10/4.20/4.35/4.40 V
    assign term_sel = ctrl[`LICS_TERM_SEL_LSB +: 2];  // 5/7.5/10/20 percent

    // all comparators cross into core_clk first
    lics_sync #(.W($bits(lics_sense_t) + 2)) u_sync (
        .clk      (core_clk),
        .rst      (rst),
        .async_in ({sense, input_low_lockout, input_high_lockout}),
        .sync_out ({sn, lock_raw})
    );
    assign lock_s = |lock_raw;

    // safety period decode; code 3 disables the timer
    function automatic logic [TMR_W-1:0] safety_limit(input logic [1:0] sel);
        case (sel)
            2'h0:    return TMR_W'(SAFETY_A_MS);
            2'h1:    return TMR_W'(SAFETY_B_MS);
            default: return TMR_W'(SAFETY_C_MS);
        endcase
    endfunction : safety_limit

    // entry point of a new or resumed charge cycle
    function automatic lics_state_t entry_state(input lics_sense_t s, input logic pre);
        if (s.below_short) begin
            return ST_SHORT_RECOVER;
        end else if (s.below_precond && pre) begin
            return ST_PRECOND;
        end
        return ST_FAST_CC;
    endfunction : entry_state

    // millisecond prescaler shared by every long timer
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ms_cnt <= '0;
        end else if (lock_s || ms_tick) begin
            ms_cnt <= '0;
        end else begin
            ms_cnt <= ms_cnt + 1'b1;
        end
    end
    assign ms_tick = (ms_cnt == PW'(MS_CYC - 1));

    // termination must persist a full filter window
    lics_timer #(.W(FW)) u_filter (
        .clk     (core_clk),
        .rst     (rst),
        .clear   (lock_s || state != ST_CONST_V || !sn.term_current_low),
        .tick    (1'b1),
        .limit   (FW'(FILTER_CYC)),
        .expired (filter_done)
    );

    // precondition timer runs only inside precondition
    lics_timer #(.W(TMR_W)) u_pre (
        .clk     (core_clk),
        .rst     (rst),
        .clear   (lock_s || state != ST_PRECOND),
        .tick    (ms_tick),
        .limit   (TMR_W'(PRECOND_MS)),
        .expired (pre_exp)
    );
    assign pre_done = pre_exp && ctrl[`LICS_PRE_TMR_BIT];

    // safety timer zeroed outside cc/cv, so entering cc restarts it
    lics_timer #(.W(TMR_W)) u_safety (
        .clk     (core_clk),
        .rst     (rst),
        .clear   (lock_s || (state != ST_FAST_CC && state != ST_CONST_V)),
        .tick    (ms_tick),
        .limit   (safety_limit(safe_sel)),
        .expired (safety_exp)
    );
    assign safety_done = safety_exp && (safe_sel != `LICS_SAFE_OFF);

    // half-period flash timer, restarted at each phase change
    lics_timer #(.W(TMR_W)) u_flash (
        .clk     (core_clk),
        .rst     (rst),
        .clear   (lock_s || !in_fault || flash_exp),
        .tick    (ms_tick),
        .limit   (TMR_W'(FLASH_HALF_MS)),
        .expired (flash_exp)
    );

    assign in_fault  = (state == ST_TEMP_FAULT) || (state == ST_TIMER_FAULT) || (state == ST_PRE_TIMER_FAULT);
    assign in_charge = (state == ST_PRECOND) || (state == ST_FAST_CC) || (state == ST_CONST_V);

    // next-state logic
    always_comb begin
        next_state = state;
        if (state != ST_SHUTDOWN && state != ST_STANDBY
            && (!sn.batt_present || !sn.program_pin_attached)) begin
            next_state = ST_STANDBY;  // battery or program resistor gone
        end else begin
            case (state)
                ST_SHUTDOWN: next_state = ST_STANDBY;
                ST_STANDBY: begin
                    if (sn.batt_present && sn.program_pin_attached && !term_hold
                        && sn.below_recharge && !sn.above_reg_hyst) begin
                        next_state = entry_state(sn, pre_en);
                    end
                end
                ST_SHORT_RECOVER: begin
                    if (sn.die_hot) begin
                        next_state = ST_TEMP_FAULT;
                    end else if (sn.above_short_hyst) begin
                        next_state = pre_en ? ST_PRECOND : ST_FAST_CC;
                    end
                end
                ST_PRECOND: begin
                    if (sn.die_hot) begin
                        next_state = ST_TEMP_FAULT;
                    end else if (!sn.below_precond) begin
                        next_state = ST_FAST_CC;
                    end else if (pre_done) begin
                        next_state = ST_PRE_TIMER_FAULT;
                    end
                end
                ST_FAST_CC: begin
                    if (sn.die_hot) begin
                        next_state = ST_TEMP_FAULT;
                    end else if (sn.above_reg_hyst) begin
                        next_state = ST_STANDBY;
                    end else if (sn.at_regulation) begin
                        next_state = ST_CONST_V;
                    end else if (safety_done) begin
                        next_state = ST_TIMER_FAULT;
                    end
                end
                ST_CONST_V: begin
                    if (sn.die_hot) begin
                        next_state = ST_TEMP_FAULT;
                    end else if (sn.above_reg_hyst) begin
                        next_state = ST_STANDBY;
                    end else if (filter_done || safety_done) begin
                        next_state = auto_rch ? ST_COMPLETE : ST_STANDBY;
                    end
                end
                ST_COMPLETE: begin
                    if (sn.below_recharge) begin
                        next_state = entry_state(sn, pre_en);
                    end
                end
                ST_TEMP_FAULT: begin
                    if (sn.die_cooled) begin
                        next_state = entry_state(sn, pre_en);
                    end
                end
                ST_TIMER_FAULT:     next_state = ST_TIMER_FAULT;  // held until removal
                ST_PRE_TIMER_FAULT: next_state = ST_PRE_TIMER_FAULT;
                default:            next_state = ST_SHUTDOWN;
            endcase
        end
    end

    // state register; lockout forces shutdown
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state <= ST_SHUTDOWN;
        end else if (lock_s) begin
            state <= ST_SHUTDOWN;
        end else begin
            state <= next_state;
        end
    end

    // no-recharge latch: released by removal, resistor unplug or power cycle
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            term_hold <= 1'b0;
        end else if (!lock_s && state == ST_CONST_V && next_state == ST_STANDBY && !auto_rch
                     && !sn.above_reg_hyst && sn.batt_present && sn.program_pin_attached) begin
            term_hold <= 1'b1;  // release wins over set
        end else if (lock_s || !sn.batt_present || !sn.program_pin_attached) begin
            term_hold <= 1'b0;
        end
    end

    // flash phase toggles every half period while faulted
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            flash_phase <= 1'b0;
        end else if (!in_fault) begin
            flash_phase <= 1'b1;  // start each fault with the pin low
        end else if (flash_exp) begin
            flash_phase <= !flash_phase;
        end
    end

    // registered drive; open-drain pin only ever pulls low
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            drive         <= '0;
            status_pin_oe <= 1'b0;
        end else if (lock_s) begin
            drive         <= '0;  // lockout cuts current at once, not a cycle late
            status_pin_oe <= 1'b0;
        end else begin
            drive.pass_enable     <= in_charge || state == ST_SHORT_RECOVER;
            drive.detect_current  <= state == ST_SHORT_RECOVER;
            drive.precond_current <= state == ST_PRECOND;
            drive.fast_current    <= state == ST_FAST_CC;
            drive.cv_regulate     <= state == ST_CONST_V;
            drive.current_derate  <= in_charge && sn.die_warm;
            status_pin_oe         <= in_charge || (in_fault && style2 && flash_phase);
        end
    end
    assign status_pin_out = 1'b0;

    // apb: zero wait states, read data captured in the setup cycle
    assign pready  = 1'b1;
    assign pslverr = psel && penable && paddr != `LICS_CTRL_OFS && paddr != `LICS_STATUS_OFS;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl <= `LICS_CTRL_RST;
        end else if (psel && penable && pwrite && paddr == `LICS_CTRL_OFS) begin
            ctrl <= pwdata[`LICS_CTRL_W-1:0];
        end
    end

    // status read shows live sequencer state
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `LICS_CTRL_OFS:   prdata <= {22'h000000, ctrl};
                `LICS_STATUS_OFS: prdata <= {24'h000000, lock_s, status_pin_oe, flash_phase, term_hold, state};
                default:          prdata <= 32'h0000_0000;
            endcase
        end
    end

    // helper: consecutive cycles of low current in cv
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            term_run <= '0;
        end else if (state != ST_CONST_V || !sn.term_current_low || lock_s) begin
            term_run <= '0;
        end else if (term_run != {FW{1'b1}}) begin
            term_run <= term_run + 1'b1;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_lockout_shutdown: assert property (lock_s |=> state == ST_SHUTDOWN && !drive.pass_enable)
        else $error("lockout did not force shutdown");
    a_cc_timeout: assert property (state == ST_FAST_CC && safety_done && !lock_s && sn.batt_present
        && sn.program_pin_attached && !sn.die_hot && !sn.above_reg_hyst && !sn.at_regulation
        |=> state == ST_TIMER_FAULT)
        else $error("cc safety timeout missed");
    a_timer_fault_hold: assert property (state == ST_TIMER_FAULT && !lock_s && sn.batt_present
        && sn.program_pin_attached |=> state == ST_TIMER_FAULT)
        else $error("timer fault released early");
    a_cc_to_cv: assert property (state == ST_FAST_CC && sn.at_regulation && !sn.die_hot && !sn.above_reg_hyst
        && !lock_s && sn.batt_present && sn.program_pin_attached |=> state == ST_CONST_V ##1 drive.cv_regulate)
        else $error("no cc to cv switch");
    a_term_filtered: assert property (filter_done |-> term_run >= FW'(FILTER_CYC))
        else $error("termination accepted before filter window");
    a_safety_restart: assert property (state != ST_FAST_CC ##1 state == ST_FAST_CC
        |-> !safety_exp ##1 !safety_exp)
        else $error("safety timer not restarted");
    a_recharge_start: assert property (state == ST_COMPLETE && sn.below_recharge && !lock_s && sn.batt_present
        && sn.program_pin_attached |=> state inside {ST_SHORT_RECOVER, ST_PRECOND, ST_FAST_CC})
        else $error("recharge did not start");
    a_hot_suspend: assert property (in_charge && sn.die_hot && !lock_s && sn.batt_present
        && sn.program_pin_attached |=> state == ST_TEMP_FAULT ##1 !drive.pass_enable)
        else $error("thermal shutdown missed");
    a_status_low: assert property (in_charge |=> status_pin_oe && !status_pin_out)
        else $error("status not low while charging");
    a_status_hiz: assert property (state inside {ST_SHUTDOWN, ST_STANDBY, ST_COMPLETE} |=> !status_pin_oe)
        else $error("status driven in idle state");
    a_fault_style1: assert property (in_fault && !style2 |=> !status_pin_oe)
        else $error("style one fault drove status");
    a_short_detect: assert property (state == ST_SHORT_RECOVER |=> drive.detect_current
        && !drive.fast_current && !drive.precond_current)
        else $error("short recovery not limited to detect current");
    a_no_recharge_wait: assert property (term_hold && state == ST_STANDBY && sn.batt_present
        && sn.program_pin_attached && !lock_s |=> state == ST_STANDBY)
        else $error("charge restarted without reinsertion");

    c_timer_fault: cover property (state == ST_FAST_CC ##1 state == ST_TIMER_FAULT);
    c_recharge:    cover property (state == ST_COMPLETE ##1 state == ST_FAST_CC);
    c_flash:       cover property (in_fault && style2 && flash_exp);
    c_short_exit:  cover property (state == ST_SHORT_RECOVER ##1 state == ST_PRECOND);
endmodule : lics_sequencer

/* File: verif/lics_cell.sv */
`timescale 1ns/1ps
module lics_cell
    import lics_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // charger drive and bench knobs
    input  wire lics_drive_t drive,
    input  wire logic        present,
    input  wire logic        stall,
    input  wire logic        hot,
    input  wire logic        attached,
    input  wire logic [15:0] start_mv,
    // comparator view of the cell
    output lics_sense_t      sense
);
    logic [15:0] mv;
    logic [4:0]  cv_cnt;

    // cell rises with any current unless stalled, leaks only when stalled and idle
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst || !present) mv <= start_mv;
        else if (drive.pass_enable && !stall && mv < 16'h1004) mv <= mv + 16'h0014;
        else if (!drive.pass_enable && stall && mv > 16'h03E8) mv <= mv - 16'h0001;
    end

    // current tapers some time after regulation starts
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst || !drive.cv_regulate) cv_cnt <= 5'h00;
        else if (cv_cnt != 5'h1F) cv_cnt <= cv_cnt + 5'h01;
    end

    // thresholds in mV: 1700, 1850, 3000, 4100, 4200, 3900
    assign sense = {present, mv < 16'h06A4, mv > 16'h073A, mv < 16'h0BB8, mv >= 16'h1004,
                    mv > 16'h1068, mv < 16'h0F3C, cv_cnt > 5'h14, hot, hot, !hot, attached};
endmodule : lics_cell

/* File: verif/lics_sequencer_tb.sv */
`timescale 1ns/1ps
module lics_sequencer_tb;
    import lics_pkg::*;
    logic        core_clk, rst, input_low_lockout, psel, penable, pwrite, pready, pslverr;
    logic        status_pin_out, status_pin_oe, present, stall, hot, input_high_lockout, attached;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, rnd;
    logic [15:0] start_mv;
    logic [1:0]  vreg_sel, term_sel;
    lics_sense_t sense;
    lics_drive_t drive;
    int          err_count, compares, cyc, n, k;
    integer      seed;

    lics_sequencer #(.FILTER_CYC(8), .MS_CYC(4), .FLASH_HALF_MS(3), .PRECOND_MS(20),
        .SAFETY_A_MS(30), .SAFETY_B_MS(40), .SAFETY_C_MS(50)) u_dut (
        .core_clk(core_clk), .rst(rst), .input_low_lockout(input_low_lockout),
        .input_high_lockout(input_high_lockout), .sense(sense), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .drive(drive), .vreg_sel(vreg_sel), .term_sel(term_sel),
        .status_pin_out(status_pin_out), .status_pin_oe(status_pin_oe));

    lics_cell u_cell (.core_clk(core_clk), .rst(rst), .drive(drive), .present(present),
        .stall(stall), .hot(hot), .attached(attached), .start_mv(start_mv), .sense(sense));

    always #10 core_clk = ~core_clk;

    // hang guard, well beyond the longest expected run
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            final_report();
        end
    end

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk

    // one apb transfer, held until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // polls the state code; a bounded poll keeps a stuck sequence visible
    task wait_state(input logic [3:0] s);
        for (k = 0; k < 400; k++) begin
            apb(1'b0, 8'h04, 32'h0);
            if (rd[3:0] === s) break;
        end
        chk("state", {28'h0, s}, {28'h0, rd[3:0]});
    endtask : wait_state

    task final_report;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : final_report

    initial begin
        {core_clk, input_low_lockout, input_high_lockout, psel, penable, pwrite, present, stall, hot} = 9'h000;
        attached = 1'b1;
        {paddr, pwdata, err_count, compares, cyc} = '0;
        rst = 1'b1;
        start_mv = 16'h03E8;
        seed = 32'hfdb8439f;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        apb(1'b0, 8'h00, 32'h0);
        chk("ctrl_reset", 32'h0000_000D, rd);
        for (n = 0; n < 4; n++) begin
            rnd = $random(seed);
            apb(1'b1, 8'h00, rnd);
            apb(1'b0, 8'h00, 32'h0);
            chk("ctrl", {22'h0, rnd[9:0]}, rd);
            chk("selects", {28'h0, rnd[9:6]}, {28'h0, term_sel, vreg_sel});
        end
        apb(1'b0, 8'h08, 32'h0);
        chk("unmapped", 32'h1, {rd[30:0], pslverr});
        apb(1'b1, 8'h00, 32'h0000_000D);
        $display("test registers done");
        present <= 1'b1;
        wait_state(4'h2);
        chk("detect", 32'h1, {31'h0, drive.detect_current});
        wait_state(4'h3);
        chk("oe_pre", 32'h1, {31'h0, status_pin_oe});
        wait_state(4'h4);
        wait_state(4'h5);
        chk("cv", 32'h1, {31'h0, drive.cv_regulate});
        wait_state(4'h6);
        chk("oe_done", 32'h0, {31'h0, status_pin_oe});
        stall <= 1'b1;
        wait_state(4'h4);
        wait_state(4'h8);
        {start_mv, stall} <= {16'h0BB8, 1'b0};
        present <= 1'b0;
        wait_state(4'h1);
        $display("test charge done");
        present <= 1'b1;
        wait_state(4'h4);
        hot <= 1'b1;
        wait_state(4'h7);
        chk("drive_hot", 32'h0, {26'h0, drive});
        apb(1'b1, 8'h00, 32'h0000_000C);
        hot <= 1'b0;
        wait_state(4'h1);
        apb(1'b0, 8'h04, 32'h0);
        chk("hold_set", 32'h1, {31'h0, rd[4]});
        attached <= 1'b0;
        repeat (6) @(posedge core_clk);
        attached <= 1'b1;
        apb(1'b0, 8'h04, 32'h0);
        chk("hold_clear", 32'h0, {31'h0, rd[4]});
        input_low_lockout <= 1'b1;
        wait_state(4'h0);
        input_low_lockout <= 1'b0;
        wait_state(4'h1);
        input_high_lockout <= 1'b1;
        wait_state(4'h0);
        input_high_lockout <= 1'b0;
        $display("test thermal done");
        {start_mv, stall} <= {16'h07D0, 1'b1};
        present <= 1'b0;
        apb(1'b1, 8'h00, 32'h0000_000F);
        present <= 1'b1;
        wait_state(4'h9);
        repeat (8) @(posedge core_clk);
        n = 0;
        repeat (48) begin
            @(posedge core_clk);
            n += status_pin_oe;
        end
        chk("flash_low", 32'd24, n);
        present <= 1'b0;
        wait_state(4'h1);
        $display("test fault done");
        final_report();
    end
endmodule : lics_sequencer_tb
